// >>> dwp_apb_regs.sv
`timescale 1ns/1ps
module dwp_apb_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] status,
  output logic [31:0]      ctrl,
  output logic [31:0]      data,
  output logic             go_pulse
);
  import dwp_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] data;
    logic [31:0] rdata;
    logic        err;
    logic        go;
  } dwp_regs_t;

  dwp_regs_t r_r;
  dwp_regs_t r_nxt;
  logic      acc;

  assign acc = psel && penable;

  always_comb begin
    r_nxt    = r_r;
    r_nxt.go = 1'b0;
    if (psel && !penable) begin
      r_nxt.err   = 1'b0;
      r_nxt.rdata = 32'h0000_0000;
      case (paddr)
        REG_CTRL_OFS: r_nxt.rdata = r_r.ctrl;
        REG_DATA_OFS: r_nxt.rdata = r_r.data;
        REG_STAT_OFS: r_nxt.rdata = status;
        default:      r_nxt.err   = 1'b1;
      endcase
    end
    if (acc && pwrite) begin
      case (paddr)
        REG_CTRL_OFS: begin
          r_nxt.ctrl = pwdata;
          r_nxt.ctrl[CTRL_GO_BIT] = 1'b0;
          r_nxt.go = pwdata[CTRL_GO_BIT];
        end
        REG_DATA_OFS: r_nxt.data = {16'h0000, pwdata[15:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '{ctrl: CTRL_RESET, data: DATA_RESET, rdata: 32'h0000_0000, err: 1'b0, go: 1'b0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // Every access ends after one wait-free access cycle.
  assign pready   = 1'b1;
  assign pslverr  = acc && r_r.err;
  assign prdata   = r_r.rdata;
  assign ctrl     = r_r.ctrl;
  assign data     = r_r.data;
  assign go_pulse = r_r.go;
endmodule : dwp_apb_regs

// >>> dwp_host.sv
`timescale 1ns/1ps
module dwp_host #(
  parameter int HALF_CYC = dwp_pkg::SCL_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n
);
  import dwp_pkg::*;

  typedef struct packed {
    dwp_state_t  st;
    logic [15:0] cnt;
    logic [1:0]  phase;
    logic [1:0]  byte_idx;
    logic [3:0]  bit_idx;
    logic [7:0]  sh;
    logic        scl_rel;
    logic        sda_rel;
    logic        busy;
    logic        done;
    logic [2:0]  nack;
    logic        nack_any;
    logic [7:0]  shadow_a;
    logic [7:0]  shadow_b;
  } dwp_host_state_t;

  dwp_host_state_t s_r;
  dwp_host_state_t s_nxt;

  logic [31:0] ctrl;
  logic [31:0] data;
  logic [31:0] status;
  logic        go;
  logic        scl_s;
  logic        sda_s;

  dwp_apb_regs u_regs (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .status   (status),
    .ctrl     (ctrl),
    .data     (data),
    .go_pulse (go)
  );

  dwp_sync u_scl_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (scl_i),
    .dout    (scl_s)
  );

  dwp_sync u_sda_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (sda_i),
    .dout    (sda_s)
  );

  // Byte of the frame by index: address with op bit, command, data.
  function automatic logic [7:0] frame_byte(input logic [1:0] idx, input logic [31:0] c, input logic [31:0] d);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      2'd0:    b = {ADDR_FIXED_HI, c[CTRL_STRAP_LSB +: ADDR_STRAP_W], c[CTRL_NOP_BIT]};
      2'd1:    b = d[DATA_CMD_LSB +: 8];
      default: b = d[DATA_VAL_LSB +: 8];
    endcase
    return b;
  endfunction : frame_byte

  // Last cycle of a half period of the serial clock.
  function automatic logic half_end(input logic [15:0] c);
    return c == 16'(HALF_CYC - 1);
  endfunction : half_end

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.scl_rel = 1'b1;
        s_nxt.sda_rel = 1'b1;
        if (go) begin
          s_nxt.busy     = 1'b1;
          s_nxt.nack     = 3'b000;
          s_nxt.st       = ST_START;
          s_nxt.cnt      = 16'd0;
          s_nxt.byte_idx = 2'd0;
          s_nxt.sh       = frame_byte(2'd0, ctrl, data);
        end
      end
      ST_START: begin
        // Wait out a half period with both lines seen high, then pull data low.
        // A line held low by someone else restarts the wait instead of colliding.
        if (s_r.sda_rel && !(scl_s && sda_s)) begin
          s_nxt.cnt = 16'd0;
        end else if (half_end(s_r.cnt)) begin
          s_nxt.cnt = 16'd0;
          if (s_r.sda_rel) begin
            s_nxt.sda_rel = 1'b0;
          end else begin
            s_nxt.scl_rel = 1'b0;
            s_nxt.st      = ST_BIT;
            s_nxt.phase   = 2'd0;
            s_nxt.bit_idx = 4'd0;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 16'd1;
        end
      end
      ST_BIT: begin
        // Phase 0: clock low, set data. Phase 1: clock high, wait for line.
        if (s_r.phase == 2'd0) begin
          if (s_r.cnt == 16'd0) begin
            if (s_r.bit_idx == 4'(BITS_PER_BYTE - 1)) begin
              s_nxt.sda_rel = 1'b1;
            end else begin
              s_nxt.sda_rel = s_r.sh[7];
              s_nxt.sh      = {s_r.sh[6:0], 1'b0};
            end
          end
          if (half_end(s_r.cnt)) begin
            s_nxt.cnt     = 16'd0;
            s_nxt.scl_rel = 1'b1;
            s_nxt.phase   = 2'd1;
          end else begin
            s_nxt.cnt = s_r.cnt + 16'd1;
          end
        end else if (!scl_s) begin
          s_nxt.cnt = 16'd0;
        end else if (half_end(s_r.cnt)) begin
          // Data stayed put through the high time; drop the clock.
          s_nxt.cnt     = 16'd0;
          s_nxt.scl_rel = 1'b0;
          s_nxt.phase   = 2'd0;
          if (s_r.bit_idx == 4'(BITS_PER_BYTE - 1)) begin
            if (sda_s) begin
              s_nxt.nack[s_r.byte_idx] = 1'b1;
            end
            s_nxt.bit_idx = 4'd0;
            if (s_r.byte_idx == 2'd2 || sda_s) begin
              s_nxt.st = ST_STOP;
            end else begin
              s_nxt.byte_idx = s_r.byte_idx + 2'd1;
              s_nxt.sh       = frame_byte(s_r.byte_idx + 2'd1, ctrl, data);
            end
          end else begin
            s_nxt.bit_idx = s_r.bit_idx + 4'd1;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 16'd1;
        end
      end
      ST_STOP: begin
        // Clock low with data pulled, then clock up, then release data.
        if (s_r.cnt == 16'd0 && s_r.phase == 2'd0) begin
          s_nxt.sda_rel = 1'b0;
        end
        if (half_end(s_r.cnt)) begin
          s_nxt.cnt = 16'd0;
          if (s_r.phase == 2'd0) begin
            s_nxt.scl_rel = 1'b1;
            s_nxt.phase   = 2'd1;
          end else if (scl_s) begin
            s_nxt.sda_rel = 1'b1;
            s_nxt.st      = ST_GAP;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 16'd1;
        end
      end
      ST_GAP: begin
        // Bus free time before another start may follow.
        if (half_end(s_r.cnt)) begin
          s_nxt.cnt = 16'd0;
          s_nxt.st  = ST_DONE;
        end else begin
          s_nxt.cnt = s_r.cnt + 16'd1;
        end
      end
      ST_DONE: begin
        s_nxt.busy     = 1'b0;
        s_nxt.done     = 1'b1;
        s_nxt.nack_any = |s_r.nack;
        s_nxt.st       = ST_IDLE;
        // Mirror what the target now holds; no readback exists.
        if (s_r.nack == 3'b000 && !ctrl[CTRL_NOP_BIT]) begin
          case (data[DATA_CMD_LSB +: 8])
            CMD_LOAD_A:  s_nxt.shadow_a = data[7:0];
            CMD_LOAD_B:  s_nxt.shadow_b = data[7:0];
            CMD_LOAD_AB: begin
              s_nxt.shadow_a = data[7:0];
              s_nxt.shadow_b = data[7:0];
            end
            default: ;
          endcase
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{st:       ST_IDLE,
               cnt:      16'd0,
               phase:    2'd0,
               byte_idx: 2'd0,
               bit_idx:  4'd0,
               sh:       8'h00,
               scl_rel:  1'b1,
               sda_rel:  1'b1,
               busy:     1'b0,
               done:     1'b0,
               nack:     3'b000,
               nack_any: 1'b0,
               shadow_a: POS_MIDSCALE,
               shadow_b: POS_MIDSCALE};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign status = {8'h00, s_r.shadow_b, s_r.shadow_a, 3'b000, s_r.nack, s_r.nack_any, s_r.busy};

  // Open-drain pins: drive low when enabled, never high.
  assign scl_o    = 1'b0;
  assign scl_oe_n = s_r.scl_rel;
  assign sda_o    = 1'b0;
  assign sda_oe_n = s_r.sda_rel;
endmodule : dwp_host

// >>> dwp_host_chk.sv
`timescale 1ns/1ps
module dwp_host_chk #(
  parameter int HALF_CYC = dwp_pkg::SCL_HALF_CYC
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_n,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_n
);
  logic       scl_q_r, sda_q_r, start_ev, stop_ev, rise_ev;
  logic [5:0] rise_cnt_r;
  logic [9:0] low_cnt_r;
  assign start_ev = sda_q_r & ~sda_oe_n & scl_oe_n;
  assign stop_ev  = ~sda_q_r & sda_oe_n & scl_oe_n;
  assign rise_ev  = ~scl_q_r & scl_oe_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
      rise_cnt_r <= 6'h0;
      low_cnt_r  <= 10'h0;
    end else begin
      scl_q_r    <= scl_oe_n;
      sda_q_r    <= sda_oe_n;
      rise_cnt_r <= start_ev ? 6'h0 : rise_cnt_r + {5'h0, rise_ev};
      low_cnt_r  <= scl_oe_n ? 10'h0 : low_cnt_r + 10'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0) else $error("line driven high");
  idle_rel_a: assert property ($rose(presetn) |-> scl_oe_n && sda_oe_n) else $error("lines busy");
  start_hold_a: assert property (start_ev |=> scl_oe_n [*3]) else $error("start too short");
  stop_free_a: assert property (stop_ev |=> (scl_oe_n && sda_oe_n) [*8]) else $error("bus not freed");
  data_stable_a: assert property (rise_ev |-> $stable(sda_oe_n) [*4]) else $error("data moved");
  pulse_cnt_a: assert property (stop_ev |-> rise_cnt_r inside {6'd10, 6'd19, 6'd28}) else $error("bad count");
  low_len_a: assert property (rise_ev |-> low_cnt_r >= 10'(HALF_CYC)) else $error("clock low short");
  apb_rsp_a: assert property (psel && penable |-> pready && (pslverr == !(paddr inside {8'h00, 8'h04, 8'h08})))
    else $error("bad bus response");
  full_frame_c: cover property (stop_ev && rise_cnt_r == 6'd28);
  nack_frame_c: cover property (stop_ev && rise_cnt_r == 6'd10);
  apb_err_c: cover property (psel && penable && pslverr);
endmodule : dwp_host_chk
bind dwp_host dwp_host_chk #(.HALF_CYC(HALF_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
);

// >>> dwp_host_tb.sv
`timescale 1ns/1ps
module dwp_host_tb;
  import dwp_pkg::*;
  typedef struct packed {
    logic [2:0] ms;
    logic [2:0] hs;
    logic       nop;
    logic [7:0] cmd;
    logic [7:0] val;
    logic [7:0] ea;
    logic [7:0] eb;
    logic       nack;
  } dwp_row_t;
  localparam dwp_row_t ROWS [6] = '{
    '{3'h5, 3'h5, OP_WRITE, CMD_LOAD_A, 8'h00, 8'h00, 8'h80, 1'b0},
    '{3'h5, 3'h5, OP_WRITE, CMD_LOAD_B, 8'hff, 8'h00, 8'hff, 1'b0},
    '{3'h0, 3'h0, OP_WRITE, CMD_LOAD_AB, 8'h5a, 8'h5a, 8'h5a, 1'b0},
    '{3'h7, 3'h7, OP_NOP, CMD_LOAD_A, 8'h33, 8'h5a, 8'h5a, 1'b0},
    '{3'h7, 3'h7, OP_WRITE, 8'h20, 8'h44, 8'h5a, 8'h5a, 1'b0},
    '{3'h3, 3'h6, OP_WRITE, CMD_LOAD_A, 8'h77, 8'h5a, 8'h5a, 1'b1}
  };
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, sda_rel, scl_w, sda_w, e;
  logic [7:0]  paddr, pos_a, pos_b;
  logic [2:0]  strap;
  logic [31:0] pwdata, prdata, q;
  int          mismatches, samples_checked, cyc;
  // Open-drain lines with pull-ups: low when any party pulls.
  assign scl_w = scl_oe_n ? 1'b1 : scl_o;
  assign sda_w = (sda_oe_n ? 1'b1 : sda_o) & sda_rel;
  dwp_host #(.HALF_CYC(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
  );
  dwp_tgt_model u_tgt (
    .scl(scl_w), .sda(sda_w), .addr_strap(strap), .sda_rel(sda_rel), .pos_a(pos_a), .pos_b(pos_b)
  );
  always #5 pclk = ~pclk;
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic go(input dwp_row_t r);
    strap <= r.ms;
    apb(1'b1, REG_DATA_OFS, (32'(r.cmd) << DATA_CMD_LSB) | 32'(r.val), q, e);
    apb(1'b1, REG_CTRL_OFS, (32'(r.hs) << CTRL_STRAP_LSB) | (32'(r.nop) << CTRL_NOP_BIT) | 32'h1, q, e);
  endtask : go
  task automatic frame(input dwp_row_t r);
    go(r);
    repeat (4) @(posedge pclk);
    do apb(1'b0, REG_STAT_OFS, 32'h0, q, e); while (q[0] !== 1'b0);
  endtask : frame
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      $display("FAIL at %0t: timeout", $time);
      results();
    end
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, strap} = '0;
    {mismatches, samples_checked, cyc} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check({16'h0, pos_b, pos_a}, 32'h8080);
    apb(1'b0, REG_STAT_OFS, 32'h0, q, e);
    check(32'(q[23:0]), 32'h0080_8000);
    apb(1'b0, REG_DATA_OFS, 32'h0, q, e);
    check(q, DATA_RESET);
    apb(1'b0, REG_CTRL_OFS, 32'h0, q, e);
    check(q, CTRL_RESET);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    check({e, q[30:0]}, 32'h8000_0000);
    $display("reset test done");
    foreach (ROWS[i]) begin
      frame(ROWS[i]);
      check(32'(q[23:8]), {16'h0, ROWS[i].eb, ROWS[i].ea});
      check(32'(q[1]), 32'(ROWS[i].nack));
      check(32'(q[4:2]), 32'(ROWS[i].nack));
      check({16'h0, pos_b, pos_a}, {16'h0, ROWS[i].eb, ROWS[i].ea});
      $display("row %0d done", i);
    end
    go('{3'h5, 3'h5, OP_WRITE, CMD_LOAD_A, 8'h01, 8'h00, 8'h00, 1'b0});
    repeat (60) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_STAT_OFS, 32'h0, q, e);
    check(32'(q[23:0]), 32'h0080_8000);
    frame('{3'h5, 3'h5, OP_WRITE, CMD_LOAD_A, 8'h01, 8'h00, 8'h00, 1'b0});
    check(32'(q[23:8]), 32'h8001);
    check({16'h0, pos_b, pos_a}, 32'h5a01);
    $display("mid-frame reset test done");
    results();
  end
endmodule : dwp_host_tb

// >>> dwp_pkg.sv
package dwp_pkg;

  // Target address layout: fixed upper four bits, three strap bits below.
  localparam logic [3:0] ADDR_FIXED_HI = 4'h5;
  localparam int         ADDR_STRAP_W  = 3;

  // Command codes understood by the target.
  localparam logic [7:0] CMD_LOAD_A    = 8'h11;
  localparam logic [7:0] CMD_LOAD_B    = 8'h12;
  localparam logic [7:0] CMD_LOAD_AB   = 8'h13;

  // Wiper position codes.
  localparam logic [7:0] POS_MIDSCALE  = 8'h80;
  localparam logic [7:0] POS_LOW_END   = 8'h00;
  localparam logic [7:0] POS_HIGH_END  = 8'hff;
  localparam int         TAP_COUNT     = 256;

  // Operation bit values.
  localparam logic       OP_WRITE      = 1'b0;
  localparam logic       OP_NOP        = 1'b1;

  // Serial clock timing at 100 MHz.
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         SCL_HALF_NS   = 1300;
  localparam int         SCL_HALF_CYC  = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         BITS_PER_BYTE = 9;

  // Own APB registers, byte addresses.
  localparam logic [7:0] REG_CTRL_OFS  = 8'h00;
  localparam logic [7:0] REG_DATA_OFS  = 8'h04;
  localparam logic [7:0] REG_STAT_OFS  = 8'h08;

  // Control register fields.
  localparam int         CTRL_GO_BIT   = 0;
  localparam int         CTRL_NOP_BIT  = 1;
  localparam int         CTRL_STRAP_LSB = 4;

  // Data register fields.
  localparam int         DATA_CMD_LSB  = 8;
  localparam int         DATA_VAL_LSB  = 0;

  // Reset values.
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET   = 32'h0000_1180;

  typedef struct packed {
    logic        scl_o;
    logic        scl_oe_n;
    logic        sda_o;
    logic        sda_oe_n;
  } dwp_pins_t;

  typedef struct packed {
    logic        start;
    logic        stop;
    logic        bit_valid;
    logic        bit_val;
  } dwp_line_ev_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_START = 6'b000010,
    ST_BIT   = 6'b000100,
    ST_STOP  = 6'b001000,
    ST_GAP   = 6'b010000,
    ST_DONE  = 6'b100000
  } dwp_state_t;

endpackage : dwp_pkg

// >>> dwp_sync.sv
`timescale 1ns/1ps
module dwp_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  import dwp_pkg::*;

  typedef struct packed {
    logic [2:0] sh;
    logic       q;
  } dwp_sync_t;

  dwp_sync_t s_r;
  dwp_sync_t s_nxt;

  // Three shift flops and an output flop; the output only moves once the last two stages agree.
  always_comb begin
    s_nxt    = s_r;
    s_nxt.sh = {s_r.sh[1:0], din};
    if (s_r.sh[1] == s_r.sh[2]) begin
      s_nxt.q = s_r.sh[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{sh: 3'b111, q: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.q;
endmodule : dwp_sync

// >>> dwp_tgt_model.sv
`timescale 1ns/1ps
module dwp_tgt_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [2:0] addr_strap,
  output logic            sda_rel,
  output logic [7:0]      pos_a,
  output logic [7:0]      pos_b
);
  logic [7:0] sh;
  logic [7:0] cmd;
  logic       act;
  logic       wr;
  int         nbit;
  int         nbyte;
  initial begin
    pos_a   = 8'h80;
    pos_b   = 8'h80;
    sda_rel = 1'b1;
    act     = 1'b0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act   = 1'b1;
      nbit  = 0;
      nbyte = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) act = 1'b0;
  end
  always @(posedge scl) begin
    if (act && nbit < 8) sh = {sh[6:0], sda};
    if (act) nbit++;
  end
  always @(negedge scl) begin
    if (act && nbit == 8) begin
      sda_rel = 1'b0;
      if (nbyte == 0) begin
        wr = (sh[0] == 1'b0);
        if (sh[7:1] != {4'h5, addr_strap}) begin
          sda_rel = 1'b1;
          act     = 1'b0;
        end
      end else if (nbyte == 1) begin
        cmd = sh;
      end else if (nbyte == 2 && wr) begin
        if (cmd == 8'h11 || cmd == 8'h13) pos_a = sh;
        if (cmd == 8'h12 || cmd == 8'h13) pos_b = sh;
      end
    end else if (act && nbit == 9) begin
      sda_rel = 1'b1;
      nbit    = 0;
      nbyte++;
    end
  end
endmodule : dwp_tgt_model
